// *** verilog/afc_consts.svh ***
// constants for the automatic flow control block: offsets, field positions, reset values
// assumes nothing beyond a SystemVerilog compiler; definitions only
`ifndef AFC_CONSTS_SVH
`define AFC_CONSTS_SVH
`define FLOW_CONTROL_CONFIG_OFFSET     12'h0ac
`define AFC_STAT_OFFSET    12'h0b0
`define AFC_PTIME_OFFSET   12'h0b4
`define FILL_HIGH_THRESHOLD_MSB         23
`define FILL_HIGH_THRESHOLD_LSB         16
`define FILL_LOW_THRESHOLD_MSB         15
`define FILL_LOW_THRESHOLD_LSB         8
`define AFC_DUR_MSB        7
`define AFC_DUR_LSB        4
`define AFC_BIT_MULT       3
`define AFC_BIT_BRD        2
`define AFC_BIT_ADDR       1
`define AFC_BIT_ANY        0
`define FLOW_CONTROL_CONFIG_RESET      32'h0000_0000
`define FLOW_CONTROL_CONFIG_MASK       32'h00ff_ffff
`define AFC_PTIME_RESET    16'h0000
`define AFC_UNIT_SHIFT     6
`define AFC_JAM_STEP_NS    1000
`define AFC_CLK_NS         25
`define AFC_JAM_STEP_CYC   ((`AFC_JAM_STEP_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`endif

// *** verilog/afc_pkg.sv ***
// types shared by the automatic flow control block
// assumes afc_consts.svh supplies the numbers
`default_nettype none
package afc_pkg;
	typedef enum logic [1:0] {AFC_IDLE, AFC_PAUSED, AFC_JAM} afc_state_t;
	typedef enum logic [1:0] {AFC_BUS_IDLE, AFC_BUS_RESP} afc_bus_t;
endpackage
`default_nettype wire

// *** verilog/afc_flow_ctrl.sv ***
// automatic flow control engine with its AXI4-Lite register slave
// assumes a MAC that takes pause requests as one-cycle pulses, and frame events from rx logic
//
// Overview of operation
// - The high threshold field 23:16, in 64-byte units, is the fill level that triggers flow control.
// - In full duplex one pause frame carrying the programmed pause time is sent when high is reached.
// - In half duplex an incoming frame matching the enabled criteria is jammed for the set duration once high is reached.
// - The low threshold field 15:8 triggers a zero-time pause once the fill drops below it.
// - The zero-time pause goes out only after high was reached and a non-zero pause was sent.
// - Field 7:4 sets how long automatic back pressure is held and does nothing in full duplex.
// - Bit 3 jams multicast frames in half duplex once the threshold is reached.
// - Bit 2 jams broadcast frames in half duplex once the threshold is reached.
// - Bit 1 jams frames addressed to this station in half duplex once the threshold is reached.
// - With the transmitter disabled no pause frame is sent and no back pressure is applied.
// - Bit 0 acts on any received frame and enables full-duplex flow control.
// - Bit 0 in half duplex acts on a valid preamble without address decode.
`timescale 1ns/10ps
`include "afc_consts.svh"
`default_nettype none
module afc_flow_ctrl #(
	parameter int FILL_W = 14
) (
	input  wire logic              core_clk,
	input  wire logic              arst_n,
	input  wire logic [11:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [11:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [FILL_W-1:0] rx_fill_bytes,
	input  wire logic              full_duplex,
	input  wire logic              tx_enabled,
	input  wire logic              rx_preamble,
	input  wire logic              rx_frame_mcast,
	input  wire logic              rx_frame_bcast,
	input  wire logic              rx_frame_own,
	output logic                   pause_req,
	output logic [15:0]            pause_time_value,
	output logic                   jam_active
);
	import afc_pkg::*;

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	typedef struct packed {
		logic [31:0] cfg;
		logic [15:0] ptime;
		afc_state_t  st;
		logic [15:0] jam_cnt;
		logic        pause_req;
		logic [15:0] pause_val;
		logic        jam;
		logic        aw_got;
		logic [11:0] aw_addr;
		logic        w_got;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} afc_regs_t;

	afc_regs_t s_r;
	afc_regs_t s_nxt;

	// duration code to jam length in clock cycles: 2*code+2 steps of AFC_JAM_STEP_CYC each
	function automatic logic [15:0] afc_jam_len(input logic [3:0] code);
		logic [15:0] steps;
		steps = {11'h000, code, 1'b0} + 16'h0002;
		return steps * 16'(`AFC_JAM_STEP_CYC);
	endfunction

	// byte-lane merge, used by both writable registers
	function automatic logic [31:0] afc_merge(input logic [31:0] old_v,
	                                          input logic [31:0] new_v,
	                                          input logic [3:0]  strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	logic [FILL_W-1:0] hi_bytes;
	logic [FILL_W-1:0] lo_bytes;
	logic              above_hi;
	logic              below_lo;
	logic              any_trig;
	logic              frame_hit;
	logic              bus_wr;
	logic [31:0]       ptime_merged;

	// -------------------------------------------------------------
	// threshold compare
	// -------------------------------------------------------------
	// high level in 64-byte units
	assign hi_bytes = FILL_W'({s_r.cfg[`FILL_HIGH_THRESHOLD_MSB:`FILL_HIGH_THRESHOLD_LSB], 6'h00});
	assign lo_bytes = FILL_W'({s_r.cfg[`FILL_LOW_THRESHOLD_MSB:`FILL_LOW_THRESHOLD_LSB], 6'h00});
	assign above_hi = rx_fill_bytes >= hi_bytes;
	assign below_lo = rx_fill_bytes < lo_bytes;
	assign any_trig = s_r.cfg[`AFC_BIT_ANY];

	// half-duplex frame match; the duplex check lives in the state machine
	// multicast trigger
	// any-frame acts on the preamble, no address decode
	assign frame_hit = (any_trig & rx_preamble)
	                 | (s_r.cfg[`AFC_BIT_MULT] & rx_frame_mcast)
	                 | (s_r.cfg[`AFC_BIT_BRD] & rx_frame_bcast)
	                 | (s_r.cfg[`AFC_BIT_ADDR] & rx_frame_own);

	assign bus_wr = s_r.aw_got & s_r.w_got & ~s_r.bvalid;

	// pause time sits in the low half of its word; upper lanes are dropped
	assign ptime_merged = afc_merge({16'h0000, s_r.ptime}, s_r.w_data, s_r.w_strb);

	// -------------------------------------------------------------
	// next state
	// -------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.pause_req = 1'b0;

		// flow control engine
		case (s_r.st)
			AFC_IDLE: begin
				s_nxt.jam = 1'b0;
				if (tx_enabled && full_duplex && any_trig && above_hi) begin
					s_nxt.pause_req = 1'b1;
					s_nxt.pause_val = s_r.ptime;
					s_nxt.st        = AFC_PAUSED;
				// jam a matching frame above threshold
				end else if (tx_enabled && !full_duplex && above_hi && frame_hit) begin
					s_nxt.jam     = 1'b1;
					s_nxt.jam_cnt = afc_jam_len(s_r.cfg[`AFC_DUR_MSB:`AFC_DUR_LSB]);
					s_nxt.st      = AFC_JAM;
				end
			end
			AFC_PAUSED: begin
				// zero pause only follows a sent non-zero pause
				if (below_lo && tx_enabled && full_duplex && any_trig) begin
					s_nxt.pause_req = 1'b1;
					s_nxt.pause_val = 16'h0000;
					s_nxt.st        = AFC_IDLE;
				end else if (!full_duplex || !any_trig) begin
					s_nxt.st = AFC_IDLE; // mode left: forget the pending resume
				end
			end
			AFC_JAM: begin
				// hold back pressure for the selected time
				if (s_r.jam_cnt <= 16'h0001 || !tx_enabled || full_duplex) begin
					s_nxt.jam = 1'b0;
					s_nxt.st  = AFC_IDLE;
				end else begin
					s_nxt.jam_cnt = s_r.jam_cnt - 16'h0001;
				end
			end
			default: s_nxt.st = AFC_IDLE;
		endcase

		// transmitter off blocks every pause and jam
		if (!tx_enabled) begin
			s_nxt.pause_req = 1'b0;
			s_nxt.jam       = 1'b0;
		end

		// write address and data taken in either order
		if (s_axi_awvalid && !s_r.aw_got) begin
			s_nxt.aw_got  = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_r.w_got) begin
			s_nxt.w_got  = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end
		if (bus_wr) begin
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = 2'b00;
			if (s_r.aw_addr[11:2] == 10'(`FLOW_CONTROL_CONFIG_OFFSET >> 2)) begin
				s_nxt.cfg = afc_merge(s_r.cfg, s_r.w_data, s_r.w_strb) & `FLOW_CONTROL_CONFIG_MASK;
			end else if (s_r.aw_addr[11:2] == 10'(`AFC_PTIME_OFFSET >> 2)) begin
				s_nxt.ptime = ptime_merged[15:0];
			end else if (s_r.aw_addr[11:2] != 10'(`AFC_STAT_OFFSET >> 2)) begin
				s_nxt.bresp = 2'b10; // unmapped: slave error
			end
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got  = 1'b0;
		end

		// read path: one read in flight, data registered
		if (s_axi_arvalid && !s_r.rvalid) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp  = 2'b00;
			if (s_axi_araddr[11:2] == 10'(`FLOW_CONTROL_CONFIG_OFFSET >> 2)) begin
				s_nxt.rdata = s_r.cfg;
			end else if (s_axi_araddr[11:2] == 10'(`AFC_PTIME_OFFSET >> 2)) begin
				s_nxt.rdata = {16'h0000, s_r.ptime};
			end else if (s_axi_araddr[11:2] == 10'(`AFC_STAT_OFFSET >> 2)) begin
				s_nxt.rdata = {28'h0000000, below_lo, above_hi, s_r.jam,
				               s_r.st == AFC_PAUSED};
			end else begin
				s_nxt.rdata = 32'h0000_0000;
				s_nxt.rresp = 2'b10;
			end
		end else if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
	end

	// -------------------------------------------------------------
	// state register
	// -------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_r       <= '0;
			s_r.cfg   <= `FLOW_CONTROL_CONFIG_RESET;
			s_r.ptime <= `AFC_PTIME_RESET;
			s_r.st    <= AFC_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// handshake readies come straight from the registered capture flags; bvalid rises the cycle after both halves are taken
	assign s_axi_awready    = ~s_r.aw_got;
	assign s_axi_wready     = ~s_r.w_got;
	assign s_axi_bvalid     = s_r.bvalid;
	assign s_axi_bresp      = s_r.bresp;
	assign s_axi_arready    = ~s_r.rvalid;
	assign s_axi_rvalid     = s_r.rvalid;
	assign s_axi_rdata      = s_r.rdata;
	assign s_axi_rresp      = s_r.rresp;
	assign pause_req        = s_r.pause_req;
	assign pause_time_value = s_r.pause_val;
	assign jam_active       = s_r.jam;
endmodule // afc_flow_ctrl
`default_nettype wire

// *** verification/afc_flow_ctrl_props.sv ***
// port checker for the flow control block
// assumes a bind onto afc_flow_ctrl, one clock domain
`timescale 1ns/10ps
`default_nettype none
module afc_flow_ctrl_props (
	input wire logic        core_clk,
	input wire logic        arst_n,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        full_duplex,
	input wire logic        tx_enabled,
	input wire logic        pause_req,
	input wire logic [15:0] pause_time_value,
	input wire logic        jam_active
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// ----------
	// assertions
	// ----------
	a_pause_one_cycle: assert property (pause_req |=> !pause_req)
		else $error("pause request held too long");
	a_pause_tx_off: assert property (!tx_enabled |=> !pause_req)
		else $error("pause while transmitter off");
	a_jam_tx_off: assert property (!tx_enabled |=> !jam_active)
		else $error("jam while transmitter off");
	a_jam_not_full: assert property (full_duplex |=> !$rose(jam_active))
		else $error("jam started in full duplex");
	a_pause_not_half: assert property (!full_duplex |=> !pause_req)
		else $error("pause sent in half duplex");
	a_time_with_pulse: assert property ($changed(pause_time_value) |-> pause_req)
		else $error("pause time moved without a pulse");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	cover property (pause_req);
	cover property ($rose(jam_active));
	cover property (s_axi_arvalid && s_axi_arready);
endmodule // afc_flow_ctrl_props
`default_nettype wire

// *** verification/afc_far_station.sv ***
// far station model: frame events toward the block, pause frames counted
// assumes the block's clock; event pulses last one cycle
`timescale 1ns/10ps
`default_nettype none
module afc_far_station (
	input  wire logic        core_clk,
	input  wire logic        pause_req,
	input  wire logic [15:0] pause_time_value,
	output logic             rx_preamble = 1'b0,
	output logic             rx_frame_mcast = 1'b0,
	output logic             rx_frame_bcast = 1'b0,
	output logic             rx_frame_own = 1'b0
);
	int unsigned n_pause = 0;
	logic [15:0] last_time = 16'h0000;
	always @(posedge core_clk) begin
		if (pause_req) begin
			n_pause <= n_pause + 1;
			last_time <= pause_time_value;
		end
	end
	// preamble leads, class follows; kind 0 = preamble only
	task automatic send(input int kind);
		@(posedge core_clk);
		rx_preamble <= 1'b1;
		@(posedge core_clk);
		rx_preamble <= 1'b0;
		if (kind > 0) {rx_frame_mcast, rx_frame_bcast, rx_frame_own} <= 3'(3'h1 << (kind - 1));
		@(posedge core_clk);
		{rx_frame_mcast, rx_frame_bcast, rx_frame_own} <= 3'h0;
	endtask
endmodule // afc_far_station
`default_nettype wire

// *** verification/tb_afc_flow_ctrl.sv ***
// self-checking bench for the flow control block
// assumes the far station model and the checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_afc_flow_ctrl;
	logic        core_clk = 1'b0, arst_n = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, pause_req, jam_active;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [13:0] rx_fill_bytes = 14'h0000;
	logic        full_duplex = 1'b1, tx_enabled = 1'b1;
	logic        rx_preamble, rx_frame_mcast, rx_frame_bcast, rx_frame_own;
	logic [15:0] pause_time_value;
	int          n_fail = 0, samples_checked = 0, n;
	afc_flow_ctrl #(.FILL_W(14)) afc_flow_ctrl_i (.*);
	afc_far_station afc_far_station_i (.*);
	initial forever #12.5 core_clk = ~core_clk;
	// ----------
	// tasks
	// ----------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		bit pa = 1'b1, pw = 1'b1;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		while (pa || pw) begin
			@(posedge core_clk);
			if (s_axi_awready) pa = 1'b0;
			if (s_axi_wready) pw = 1'b0;
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end
		do @(posedge core_clk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(posedge core_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge core_clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic flow(input logic [13:0] f, input int c, input logic [15:0] t);
		@(posedge core_clk);
		rx_fill_bytes <= f;
		repeat (6) @(posedge core_clk);
		chk(afc_far_station_i.n_pause, c);
		chk(afc_far_station_i.last_time, t);
	endtask
	// jam length in cycles, zero if it never rose
	task automatic jam(input int e);
		n = 0;
		@(posedge core_clk);
		while (jam_active === 1'b1 && n < 2000) begin
			n++;
			@(posedge core_clk);
		end
		chk(n, e);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#500000;
		n_fail++;
		close_out;
	end
	// ----------
	// scenarios
	// ----------
	initial begin
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		rd(12'h0ac);
		chk(d, 32'h0000_0000);
		wr(12'h0ac, 32'hffff_ffff);
		rd(12'h0ac);
		chk(d, 32'h00ff_ffff);
		rd(12'h0c0);
		chk({30'h0, r}, 32'h0000_0002);
		wr(12'h0c0, 32'h0000_0001);
		chk({30'h0, r}, 32'h0000_0002);
		wr(12'h0b4, 32'h0000_1234);
		chk({30'h0, r}, 32'h0000_0000);
		rd(12'h0b4);
		chk(d, 32'h0000_1234);
		wr(12'h0ac, 32'h0004_0201);
		flow(14'd255, 0, 16'h0000);
		flow(14'd256, 1, 16'h1234);
		flow(14'd300, 1, 16'h1234);
		flow(14'd128, 1, 16'h1234);
		flow(14'd127, 2, 16'h0000);
		tx_enabled <= 1'b0;
		flow(14'd256, 2, 16'h0000);
		tx_enabled <= 1'b1;
		flow(14'd256, 3, 16'h1234);
		rd(12'h0b0);
		chk(d, 32'h0000_0005);
		wr(12'h0ac, 32'h0004_020e);
		flow(14'd0, 3, 16'h1234);
		flow(14'd256, 3, 16'h1234);
		afc_far_station_i.send(3);
		jam(0);
		full_duplex <= 1'b0;
		wr(12'h0ac, 32'h0004_0208);
		flow(14'd255, 3, 16'h1234);
		afc_far_station_i.send(3);
		jam(0);
		flow(14'd256, 3, 16'h1234);
		for (int k = 0; k < 4; k++) begin
			wr(12'h0ac, 32'h0004_0200 | (32'h1 << k) | (k << 4));
			if (k > 0) begin
				afc_far_station_i.send(k % 3 + 1);
				jam(0);
			end
			afc_far_station_i.send(k);
			jam((2 * k + 2) * 40 - (k == 0));
		end
		tx_enabled <= 1'b0;
		afc_far_station_i.send(3);
		jam(0);
		close_out;
	end
endmodule // tb_afc_flow_ctrl
bind afc_flow_ctrl afc_flow_ctrl_props afc_flow_ctrl_props_i (.*);
`default_nettype wire
